// *** verilog/gesr_top.sv ***
// Global event and status registers of an eight-port power controller.
// Assumes a register read strobe from the serial management front end,
// comparator levels synchronous to I_CORE_CLK, and straps stable at reset.
`timescale 1ns/1ps
module gesr_top #(
    parameter int unsigned EVAL_CYCLES = gesr_pkg::EVAL_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_RD_STB,
    input wire logic [gesr_pkg::ADDR_W-1:0] I_RD_ADDR,
    input wire logic I_OVERTEMP,
    input wire logic I_TEMP_ABOVE_SAFE,
    input wire logic I_TSD_DISABLE,
    input wire logic I_LOGIC_SUPPLY_BELOW,
    input wire logic I_PORT_SUPPLY_ABOVE_LO,
    input wire logic I_PORT_SUPPLY_ABOVE_HI,
    input wire logic [gesr_pkg::NUM_PORTS-1:0] I_DET_START,
    input wire logic [gesr_pkg::NUM_PORTS-1:0] I_FET_LEAKY,
    input wire logic [gesr_pkg::NUM_PORTS-1:0] I_PORTS_POWERED,
    input wire logic [gesr_pkg::SLAVE_ADDR_W-1:0] I_SLAVE_ADDR,
    input wire logic I_AUTO_PIN,
    output logic [gesr_pkg::DATA_W-1:0] O_RD_DATA,
    output logic O_RD_VALID,
    output logic [gesr_pkg::NUM_PORTS-1:0] O_PORT_FET_BAD,
    output logic O_PORTS_OFF,
    output logic O_THERMAL_OFF,
    output logic O_PORT_SUPPLY_LOW
);
    import gesr_pkg::*;

    localparam int CNT_W = $clog2(EVAL_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(EVAL_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by the logic and its checks
    function automatic logic is_cor_read(input logic stb, input logic [ADDR_W-1:0] addr);
        is_cor_read = stb && (addr == ADDR_EVENT_COR);
    endfunction : is_cor_read

    typedef struct packed {
        gesr_state_e state;
        logic [CNT_W-1:0] tick_cnt;
        logic tick;
        logic [NUM_PORTS-1:0] fet_bad;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic ports_off;
        logic thermal_off;
    } gesr_top_s;

    gesr_top_s state_reg;
    gesr_top_s state_next;

    logic logic_low;
    logic port_low;
    logic logic_fall;
    logic port_fall;
    logic cor_read;

    gesr_evt_if #(.W(DATA_W)) ev ();

    ////////////////////////////////////////////////////////////////////////
    // Supply monitors
    gesr_supply_mon u_supply (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_logic_below(I_LOGIC_SUPPLY_BELOW),
        .i_port_above_lo(I_PORT_SUPPLY_ABOVE_LO),
        .i_port_above_hi(I_PORT_SUPPLY_ABOVE_HI),
        .o_logic_low(logic_low),
        .o_port_low(port_low),
        .o_logic_fall(logic_fall),
        .o_port_fall(port_fall)
    );

    // Sticky event register; 0x02 and 0x03 are two views of it
    gesr_event_latch #(
        .W(DATA_W),
        .RESET_VAL(EVENT_RESET)
    ) u_events (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event sources; reserved bits never set so they read zero
    assign cor_read = is_cor_read(I_RD_STB, I_RD_ADDR);
    assign ev.clear = cor_read;

    always_comb begin
        ev.set = '0;
        // Comparator level re-sampled every evaluation
        ev.set[BIT_OVERTEMP] = state_reg.tick & I_OVERTEMP;
        // Leak found at detection start, or a port still flagged bad
        ev.set[BIT_FET_BAD] = (|(I_DET_START & I_FET_LEAKY))
            | (state_reg.tick & (|state_reg.fet_bad));
        // Transition edge, plus periodic re-set while still low
        ev.set[BIT_LOGIC_LOW] = logic_fall | (state_reg.tick & logic_low);
        ev.set[BIT_PORT_LOW] = port_fall | (state_reg.tick & port_low);
        // Thermal trip that has emptied every powered port
        ev.set[BIT_TSD] = state_reg.thermal_off & ~(|I_PORTS_POWERED);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;

        // Periodic fault evaluation tick
        state_next.tick = 1'b0;
        if (state_reg.tick_cnt == CNT_LAST) begin
            state_next.tick_cnt = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + 1'b1;
        end

        // Straps are caught once, the cycle after reset is released
        case (state_reg.state)
            GESR_ST_CAPTURE: begin
                state_next.status = STATUS_RESET;
                state_next.status[STATUS_ADDR_MSB:STATUS_ADDR_LSB] = I_SLAVE_ADDR;
                state_next.status[STATUS_AUTO] = I_AUTO_PIN;
                state_next.state = GESR_ST_RUN;
            end
            GESR_ST_RUN: begin
                state_next.state = GESR_ST_RUN;
            end
            default: begin
                state_next.state = GESR_ST_CAPTURE;
            end
        endcase

        // Per-port leak results, refreshed when that port starts detection
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (I_DET_START[p]) begin
                state_next.fet_bad[p] = I_FET_LEAKY[p];
            end
        end

        // Threshold choice depends on whether over-temp shutdown is on
        state_next.thermal_off = I_TSD_DISABLE ? I_TEMP_ABOVE_SAFE : I_OVERTEMP;

        // Any supply fault or thermal trip holds every port down
        state_next.ports_off = logic_low | port_low | state_next.thermal_off;

        // Read answer; the clear-on-read view returns pre-clear content
        if (I_RD_STB) begin
            state_next.rd_valid = 1'b1;
            case (I_RD_ADDR)
                ADDR_EVENT, ADDR_EVENT_COR: begin
                    state_next.rd_data = ev.flags;
                end
                ADDR_STATUS: begin
                    state_next.rd_data = state_reg.status;
                end
                default: begin
                    state_next.rd_data = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            state_reg <= '{
                state: GESR_ST_CAPTURE,
                tick_cnt: '0,
                tick: 1'b0,
                fet_bad: '0,
                status: STATUS_RESET,
                rd_data: '0,
                rd_valid: 1'b0,
                ports_off: 1'b1,
                thermal_off: 1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    assign O_RD_DATA = state_reg.rd_data;
    assign O_RD_VALID = state_reg.rd_valid;
    assign O_PORT_FET_BAD = state_reg.fet_bad;
    assign O_PORTS_OFF = state_reg.ports_off;
    assign O_THERMAL_OFF = state_reg.thermal_off;
    assign O_PORT_SUPPLY_LOW = port_low;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking gesr_cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);

    sequence seq_cor_read;
        is_cor_read(I_RD_STB, I_RD_ADDR) && (ev.set == '0);
    endsequence

    sequence seq_event_read;
        I_RD_STB && ((I_RD_ADDR == ADDR_EVENT) || (I_RD_ADDR == ADDR_EVENT_COR));
    endsequence

    a_mirror_content: assert property (
        seq_event_read |=> O_RD_VALID && (O_RD_DATA == $past(ev.flags)))
        else $error("event read returned wrong content");

    a_cor_clears_both: assert property (
        seq_cor_read |=> ev.flags == '0)
        else $error("clear-on-read left flags set");

    a_fault_reasserts: assert property (
        state_reg.tick && port_low |=> ev.flags[BIT_PORT_LOW])
        else $error("persisting port-supply fault not re-flagged");

    a_fetbad_on_leak: assert property (
        (|(I_DET_START & I_FET_LEAKY)) |=> ev.flags[BIT_FET_BAD])
        else $error("leaky switch did not set flag");

    a_fetbad_holds: assert property (
        ev.flags[BIT_FET_BAD] && !cor_read |=> ev.flags[BIT_FET_BAD])
        else $error("bad-switch flag dropped without clearing read");

    a_port_refresh: assert property (
        I_DET_START[0] |=> O_PORT_FET_BAD[0] == $past(I_FET_LEAKY[0]))
        else $error("port bad-switch flag not refreshed");

    a_logic_low_off: assert property (
        I_LOGIC_SUPPLY_BELOW ##1 I_LOGIC_SUPPLY_BELOW |=> O_PORTS_OFF)
        else $error("ports not held off on logic undervoltage");

    a_port_low_off: assert property (
        port_low |=> O_PORTS_OFF)
        else $error("ports not held off below port-supply threshold");

    a_tsd_latch: assert property (
        O_THERMAL_OFF && (I_PORTS_POWERED == '0) |=> ev.flags[BIT_TSD])
        else $error("thermal shutdown flag not set");

    a_tsd_threshold: assert property (
        I_TSD_DISABLE && I_TEMP_ABOVE_SAFE |=> O_THERMAL_OFF)
        else $error("safe-temperature threshold ignored");

    a_status_layout: assert property (
        I_RD_STB && (I_RD_ADDR == ADDR_STATUS) |=> O_RD_DATA[7] == 1'b0 && O_RD_DATA[1] == 1'b0)
        else $error("status reserved bits not zero");

    a_reserved_zero: assert property (
        ev.flags[2:0] == 3'h0)
        else $error("reserved event bits set");

endmodule : gesr_top

// *** include/gesr_pkg.sv ***
// Constants for the global event and status register bank.
// Assumes one 250 MHz core clock and a synchronous, active-high reset.
package gesr_pkg;
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_COR = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h05;
    // Reset values
    localparam logic [DATA_W-1:0] EVENT_RESET = 8'h20;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    // Event register fields
    localparam int BIT_OVERTEMP = 7;
    localparam int BIT_FET_BAD = 6;
    localparam int BIT_LOGIC_LOW = 5;
    localparam int BIT_PORT_LOW = 4;
    localparam int BIT_TSD = 3;
    // Status register fields
    localparam int STATUS_ADDR_LSB = 2;
    localparam int STATUS_ADDR_MSB = 6;
    localparam int STATUS_AUTO = 0;
    localparam int SLAVE_ADDR_W = STATUS_ADDR_MSB - STATUS_ADDR_LSB + 1;
    // Ports
    localparam int NUM_PORTS = 8;
    // Timing: periodic fault evaluation
    localparam int CLK_PERIOD_NS = 4;
    localparam int EVAL_PERIOD_NS = 2000000;
    localparam int EVAL_CYCLES = EVAL_PERIOD_NS / CLK_PERIOD_NS;
    // Strap capture sequence
    typedef enum logic [1:0] {
        GESR_ST_CAPTURE = 2'b00,
        GESR_ST_RUN = 2'b01
    } gesr_state_e;
endpackage : gesr_pkg

// *** include/gesr_evt_if.sv ***
// Carrier between the event sources and the sticky event latch.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface gesr_evt_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic clear;
    logic [W-1:0] flags;
    modport src (output set, output clear, input flags);
    modport hold (input set, input clear, output flags);
endinterface : gesr_evt_if

// *** verilog/gesr_event_latch.sv ***
// Sticky event flags with a whole-register clear.
// Assumes set and clear are single-cycle requests on the core clock.
`timescale 1ns/1ps
module gesr_event_latch #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    gesr_evt_if.hold ev
);
    import gesr_pkg::*;

    typedef struct packed {
        logic [W-1:0] flags;
    } gesr_latch_s;

    gesr_latch_s state_reg;
    gesr_latch_s state_next;

    ////////////////////////////////////////////////////////////////////////
    // A set in the clearing cycle survives, so no event is lost
    always_comb begin
        state_next = state_reg;
        // Flags hold until the clearing read, so every bit is sticky
        state_next.flags = (state_reg.flags & ~{W{ev.clear}}) | ev.set;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '{flags: RESET_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign ev.flags = state_reg.flags;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_set_wins_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        ev.clear && (ev.set != '0) |=> ((ev.flags & $past(ev.set)) == $past(ev.set)))
        else $error("set lost against clear");
    a_flags_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !ev.clear && (ev.set == '0) |=> ev.flags == $past(ev.flags))
        else $error("flag changed without cause");
endmodule : gesr_event_latch

// *** verilog/gesr_supply_mon.sv ***
// Supply monitors: logic-supply level and port-supply hysteresis,
// each with a good-to-bad transition pulse.
// Assumes comparator inputs are already synchronous to the clock.
`timescale 1ns/1ps
module gesr_supply_mon (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_logic_below,
    input wire logic i_port_above_lo,
    input wire logic i_port_above_hi,
    output logic o_logic_low,
    output logic o_port_low,
    output logic o_logic_fall,
    output logic o_port_fall
);
    import gesr_pkg::*;

    typedef struct packed {
        logic logic_low;
        logic port_low;
        logic logic_fall;
        logic port_fall;
    } gesr_mon_s;

    gesr_mon_s state_reg;
    gesr_mon_s state_next;

    ////////////////////////////////////////////////////////////////////////
    // Both supplies count as bad out of reset so no false edge appears
    always_comb begin
        state_next = state_reg;
        state_next.logic_low = i_logic_below;
        if (!i_port_above_lo) begin
            state_next.port_low = 1'b1;
        end else if (i_port_above_hi) begin
            state_next.port_low = 1'b0;
        end
        state_next.logic_fall = state_next.logic_low & ~state_reg.logic_low;
        state_next.port_fall = state_next.port_low & ~state_reg.port_low;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '{logic_low: 1'b1, port_low: 1'b1, logic_fall: 1'b0, port_fall: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_logic_low = state_reg.logic_low;
    assign o_port_low = state_reg.port_low;
    assign o_logic_fall = state_reg.logic_fall;
    assign o_port_fall = state_reg.port_fall;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_hyst_band_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        i_port_above_lo && !i_port_above_hi |=> o_port_low == $past(o_port_low))
        else $error("port supply indication moved inside band");
    a_port_fall_edge: assert property (@(posedge i_clk) disable iff (i_reset)
        o_port_fall |-> o_port_low && !$past(o_port_low))
        else $error("port supply pulse without good-to-bad edge");
endmodule : gesr_supply_mon

// *** tb/gesr_host_model.sv ***
// Host model for the register bank: issues single-byte register reads.
// Assumes the core clock and the synchronous active-high reset of the bank.
`timescale 1ns/1ps
module gesr_host_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic [gesr_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_rd_valid,
    input wire logic [gesr_pkg::DATA_W-1:0] i_rd_data,
    output logic o_rd_stb = 1'b0,
    output logic [gesr_pkg::ADDR_W-1:0] o_rd_addr = 8'h00,
    output logic o_done = 1'b0,
    output logic [gesr_pkg::DATA_W-1:0] o_data = 8'h00
);
    import gesr_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Read-only host with no write path, so port registers stay untouched
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_rd_stb <= 1'b0;
            o_rd_addr <= 8'h00;
        end else if (i_go) begin
            o_rd_stb <= 1'b1;
            o_rd_addr <= i_addr;
        end else begin
            o_rd_stb <= 1'b0;
            o_rd_addr <= ~o_rd_addr; // Idle address keeps moving so a stale one never passes
        end
        o_done <= i_rd_valid;
        o_data <= i_rd_data;
    end
endmodule : gesr_host_model

// *** tb/tb_gesr_top.sv ***
// Self-checking bench for the global event and status register bank.
// Assumes a shortened evaluation period of 16 cycles and a 250 MHz clock.
`timescale 1ns/1ps
module tb_gesr_top;
    import gesr_pkg::*;
    localparam int EVAL = 16;
    logic clk, rst, go, ot, safe, dis, lbelow, plo, phi, auto, stb, valid, done;
    logic ports_off, th_off, sup_low;
    logic [7:0] addr, rd_addr, rd_data, host_data, det, leaky, pwr, fet_bad;
    logic [4:0] slv;
    int evt, mismatches, cmp_count, cyc;
    ////////////////////////////////////////////////////////////////////////
    // Design, with the evaluation tick shortened to keep the run brief
    gesr_top #(.EVAL_CYCLES(EVAL)) i_gesr_top (.I_CORE_CLK(clk), .I_RESET(rst), .I_RD_STB(stb),
        .I_RD_ADDR(rd_addr), .I_OVERTEMP(ot), .I_TEMP_ABOVE_SAFE(safe), .I_TSD_DISABLE(dis),
        .I_LOGIC_SUPPLY_BELOW(lbelow), .I_PORT_SUPPLY_ABOVE_LO(plo), .I_PORT_SUPPLY_ABOVE_HI(phi),
        .I_DET_START(det), .I_FET_LEAKY(leaky), .I_PORTS_POWERED(pwr), .I_SLAVE_ADDR(slv),
        .I_AUTO_PIN(auto), .O_RD_DATA(rd_data), .O_RD_VALID(valid), .O_PORT_FET_BAD(fet_bad),
        .O_PORTS_OFF(ports_off), .O_THERMAL_OFF(th_off), .O_PORT_SUPPLY_LOW(sup_low));
    gesr_host_model i_gesr_host_model (.i_clk(clk), .i_reset(rst), .i_go(go), .i_addr(addr),
        .i_rd_valid(valid), .i_rd_data(rd_data), .o_rd_stb(stb), .o_rd_addr(rd_addr),
        .o_done(done), .o_data(host_data));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Read through the host model; a clearing read empties the bench's expected event copy evt
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        go <= 1'b1;
        addr <= a;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        // A read that never answers must not pass on stale data
        chk({7'h0, done}, 8'h01, "read answer");
        chk(host_data, exp, "read data");
        if (a === ADDR_EVENT_COR) evt = 0;
    endtask : rd_chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    task automatic pulse_det(input logic [7:0] m, input logic [7:0] l);
        det <= m;
        leaky <= l;
        @(posedge clk);
        det <= 8'h00;
        leaky <= 8'h00;
        @(posedge clk);
    endtask : pulse_det
    task automatic clear_pair;
        rd_chk(ADDR_EVENT_COR, evt[7:0]);
        rd_chk(ADDR_EVENT, evt[7:0]);
    endtask : clear_pair
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [3:0] lo_t, hi_t;
        logic plow;
        int k;
        lo_t = 4'hD;
        hi_t = 4'h8;
        plow = 1'b0;
        k = $urandom(32'hCC16);
        k = $urandom % 8;
        rst <= 1'b1; go <= 1'b0; addr <= 8'h00; ot <= 1'b0; safe <= 1'b0; dis <= 1'b0;
        lbelow <= 1'b0; plo <= 1'b1; phi <= 1'b1; det <= 8'h00; leaky <= 8'h00; pwr <= 8'hFF;
        slv <= 5'($urandom % 32); auto <= 1'($urandom % 2);
        wait_cyc(20);
        rst <= 1'b0;
        wait_cyc(3);
        // Reset contents, status, unmapped place, clearing read
        evt = EVENT_RESET;
        rd_chk(ADDR_EVENT, evt[7:0]);
        rd_chk(ADDR_STATUS, {1'b0, slv, 1'b0, auto});
        rd_chk(8'h04, 8'h00);
        clear_pair();
        // Leaky switch on a random port, then a clean detection refresh
        pulse_det(8'h01 << k, 8'h01 << k);
        chk(fet_bad, 8'h01 << k, "port switch flags");
        evt |= 8'h40;
        wait_cyc(2 * EVAL);
        rd_chk(ADDR_EVENT, evt[7:0]);
        pulse_det(8'h01 << k, 8'h00);
        chk(fet_bad, 8'h00, "port switch flags");
        clear_pair();
        // Logic-supply dip
        lbelow <= 1'b1;
        wait_cyc(4);
        chk({7'h0, ports_off}, 8'h01, "ports off");
        evt |= 8'h20;
        lbelow <= 1'b0;
        wait_cyc(4);
        chk({7'h0, ports_off}, 8'h00, "ports off");
        clear_pair();
        // Port-supply hysteresis walk
        for (int i = 0; i < 4; i++) begin
            plo <= lo_t[i];
            phi <= hi_t[i];
            wait_cyc(4);
            plow = !lo_t[i] ? 1'b1 : (hi_t[i] ? 1'b0 : plow);
            chk({7'h0, sup_low}, {7'h0, plow}, "supply low");
            chk({7'h0, ports_off}, {7'h0, plow}, "ports off");
        end
        evt |= 8'h10;
        clear_pair();
        // Thermal threshold choice and shutdown event, both settings
        for (int d = 0; d < 2; d++) begin
            dis <= d[0];
            ot <= d[0];
            safe <= !d[0];
            wait_cyc(2 * EVAL);
            chk({7'h0, th_off}, 8'h00, "thermal off");
            evt |= (d == 1) ? 8'h80 : 8'h00;
            ot <= !d[0];
            safe <= d[0];
            wait_cyc(2 * EVAL);
            chk({7'h0, th_off}, 8'h01, "thermal off");
            evt |= (d == 0) ? 8'h80 : 8'h00;
            pwr <= 8'h00;
            wait_cyc(3);
            evt |= 8'h08;
            ot <= 1'b0;
            safe <= 1'b0;
            pwr <= 8'hFF;
            wait_cyc(3);
            clear_pair();
        end
        // Persisting hot die sets its flag again after a clearing read
        ot <= 1'b1;
        wait_cyc(2 * EVAL);
        evt |= 8'h80;
        rd_chk(ADDR_EVENT_COR, evt[7:0]);
        wait_cyc(2 * EVAL);
        evt |= 8'h80;
        rd_chk(ADDR_EVENT, evt[7:0]);
        ot <= 1'b0;
        wait_cyc(3);
        clear_pair();
        summarize();
    end
endmodule : tb_gesr_top
